// file: verilog/wdt_map.svh
// offsets, field positions, reset values and counts of the watchdog block
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ==========================================================================
// register byte offsets
`define WDT_OFS_CTRL      4'h0
`define WDT_OFS_STATUS    4'h4
`define WDT_OFS_INT_STAT  4'h8
`define WDT_OFS_INT_MASK  4'hc

// ==========================================================================
// control register fields
`define WDT_CTRL_EN_BIT   0
`define WDT_CTRL_PS_LSB   1
`define WDT_CTRL_PS_MSB   5
`define WDT_CTRL_RESET    6'h16
`define WDT_PS_RESET      5'h0b

// ==========================================================================
// status register fields
`define WDT_ST_PD_BIT     0
`define WDT_ST_TO_BIT     1
`define WDT_ST_WATCH_RESET_FLAG_BIT   2
`define WDT_ST_SLEEP_BIT  3

// ==========================================================================
// interrupt bits
`define WDT_IRQ_RESET_BIT 0
`define WDT_IRQ_WAKE_BIT  1
`define WDT_IRQ_W         2

// ==========================================================================
// prescale: code 0 divides by 2^5, top valid code divides by 2^23
`define WDT_BASE_SHIFT    5'h05
`define WDT_PS_MAX        5'h12
`define WDT_CNT_W         23

// ==========================================================================
// bus answers
`define WDT_RESP_OKAY     2'h0
`define WDT_RESP_SLVERR   2'h2

`endif

// file: verilog/wdt_pkg.sv
// types shared by the watchdog modules
package wdt_pkg;

    // ======================================================================
    // operating mode field
    typedef enum logic [1:0] {
        MODE_OFF      = 2'b00,
        MODE_SOFTWARE = 2'b01,
        MODE_AWAKE    = 2'b10,
        MODE_ALWAYS   = 2'b11
    } wdt_mode_t;

    // ======================================================================
    // bus write channel state
    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESPOND = 1'b1
    } wr_state_t;

endpackage : wdt_pkg

// file: verilog/wdt_cnt_if.sv
// carrier between watchdog control and its prescale counter
`timescale 1ns/10ps
interface wdt_cnt_if;
    logic       tick;
    logic       clear;
    logic       run;
    logic [4:0] period_sel;
    logic       timeout;

    modport ctrl (output tick, output clear, output run,
                  output period_sel, input timeout);
    modport cnt  (input tick, input clear, input run,
                  input period_sel, output timeout);
endinterface : wdt_cnt_if

// file: verilog/osc_edge_sync.sv
// two-flop synchroniser with rising edge pulse for the slow oscillator
`timescale 1ns/10ps
module osc_edge_sync (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic async_in,
    output logic      rise
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // ======================================================================
    // synchroniser chain
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // ======================================================================
    // edge pulse
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rise <= 1'b0;
        end else begin
            rise <= sync_r & ~last_r;
        end
    end
endmodule : osc_edge_sync

// file: verilog/wdt_prescale_counter.sv
// prescale counter of the watchdog, advanced by slow oscillator edges
`include "wdt_map.svh"
`timescale 1ns/10ps
module wdt_prescale_counter #(
    parameter int CNT_W = `WDT_CNT_W
) (
    input  wire logic clock,
    input  wire logic rst_b,
    wdt_cnt_if.cnt    bus
);
    logic [CNT_W-1:0] count_r;
    logic [4:0]       shift;
    logic [CNT_W-1:0] terminal;
    logic             at_end;

    // ======================================================================
    // terminal value of the selected prescale
    always_comb begin
        if (bus.period_sel <= `WDT_PS_MAX) begin
            shift = bus.period_sel + `WDT_BASE_SHIFT;
        end else begin
            shift = `WDT_BASE_SHIFT;
        end
        terminal = {CNT_W{1'b1}} >> (5'(CNT_W) - shift);
        at_end   = (count_r == terminal);
    end

    // ======================================================================
    // count only slow oscillator edges
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            count_r <= '0;
        end else if (bus.clear) begin
            count_r <= '0;
        end else if (bus.run && bus.tick) begin
            if (at_end) begin
                count_r <= '0;
            end else begin
                count_r <= count_r + 1'b1;
            end
        end
    end

    // ======================================================================
    // one-cycle time-out pulse
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bus.timeout <= 1'b0;
        end else begin
            bus.timeout <= bus.run && bus.tick && at_end
                           && !bus.clear;
        end
    end
endmodule : wdt_prescale_counter

// file: verilog/watchdog_timer_sleep_aware.sv
// watchdog timer with sleep handling, status flags and register slave
`include "wdt_map.svh"
`timescale 1ns/10ps
module watchdog_timer_sleep_aware #(
    parameter int CNT_W = `WDT_CNT_W
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    // slow oscillator pin
    input  wire logic        low_freq_int_osc,
    // core side
    input  wire logic [1:0]  wdt_mode_cfg,
    input  wire logic        clear_watch_instr,
    input  wire logic        sleep_req,
    input  wire logic        ext_wake,
    input  wire logic        osc_fail,
    output logic             wdt_reset_req,
    output logic             wake_req,
    output logic             asleep,
    output logic             timeout_flag_n,
    output logic             powerdown_flag_n,
    output logic             watch_reset_flag,
    output logic             irq,
    // register bus
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ======================================================================
    // declarations
    wdt_cnt_if               cnt_bus ();
    logic                    osc_tick;
    logic                    sw_watch_enable_r;
    logic [4:0]              watch_period_sel_r;
    logic [`WDT_IRQ_W-1:0]   int_stat_r;
    logic [`WDT_IRQ_W-1:0]   int_mask_r;
    logic [`WDT_IRQ_W-1:0]   int_set;
    logic [`WDT_IRQ_W-1:0]   int_clr;
    logic                    enabled;
    logic                    sleep_entry;
    logic                    wake_evt;
    logic                    awake_timeout;
    logic                    sleep_timeout;
    logic                    watch_reset_flag_clr;
    wdt_pkg::wdt_mode_t      mode;
    wdt_pkg::wr_state_t      wr_state_r;
    logic                    aw_held_r;
    logic                    w_held_r;
    logic [3:0]              aw_addr_r;
    logic [31:0]             w_data_r;
    logic [3:0]              w_strb_r;
    logic                    wr_fire;
    logic                    wr_lane0;
    logic                    wr_ctrl;
    logic                    wr_status;
    logic                    wr_int_stat;
    logic                    wr_int_mask;
    logic                    wr_mapped;
    logic [31:0]             rd_word;
    logic                    rd_mapped;

    // ======================================================================
    // slow oscillator crossing and prescale counter
    osc_edge_sync u_osc_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in (low_freq_int_osc),
        .rise     (osc_tick)
    );

    wdt_prescale_counter #(
        .CNT_W (CNT_W)
    ) u_counter (
        .clock (clock),
        .rst_b (rst_b),
        .bus   (cnt_bus)
    );

    // ======================================================================
    // mode decode
    always_comb begin
        mode = wdt_pkg::wdt_mode_t'(wdt_mode_cfg);
        case (mode)
            wdt_pkg::MODE_ALWAYS: begin
                enabled = 1'b1;
            end
            wdt_pkg::MODE_AWAKE: begin
                enabled = !asleep;
            end
            wdt_pkg::MODE_SOFTWARE: begin
                enabled = sw_watch_enable_r;
            end
            wdt_pkg::MODE_OFF: begin
                enabled = 1'b0;
            end
            default: begin
                enabled = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // sleep events and counter control
    always_comb begin
        sleep_entry   = sleep_req && !asleep;
        awake_timeout = cnt_bus.timeout && !asleep;
        sleep_timeout = cnt_bus.timeout && asleep;
        wake_evt      = asleep && (ext_wake || cnt_bus.timeout);
    end

    // prescale setting of the slow oscillator ticks is not a clear term
    assign cnt_bus.tick       = osc_tick;
    assign cnt_bus.run        = enabled;
    assign cnt_bus.period_sel = watch_period_sel_r;
    assign cnt_bus.clear      = clear_watch_instr || sleep_entry
                                || wake_evt || osc_fail
                                || !enabled;

    // ======================================================================
    // sleep state
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            asleep <= 1'b0;
        end else if (wake_evt) begin
            asleep <= 1'b0;
        end else if (sleep_entry) begin
            asleep <= 1'b1;
        end
    end

    // ======================================================================
    // reset and wake requests
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wdt_reset_req <= 1'b0;
            wake_req      <= 1'b0;
        end else begin
            wdt_reset_req <= awake_timeout;
            wake_req      <= wake_evt;
        end
    end

    // ======================================================================
    // time-out and power-down flags, time-out wins over other updates
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            timeout_flag_n   <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end else if (cnt_bus.timeout) begin
            timeout_flag_n   <= 1'b0;
            powerdown_flag_n <= !asleep;
        end else if (sleep_entry) begin
            timeout_flag_n   <= 1'b1;
            powerdown_flag_n <= 1'b0;
        end else if (clear_watch_instr) begin
            timeout_flag_n   <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end
    end

    // ======================================================================
    // watchdog reset record, set wins over clear
    assign watch_reset_flag_clr = wr_status && w_data_r[`WDT_ST_WATCH_RESET_FLAG_BIT];

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            watch_reset_flag <= 1'b0;
        end else begin
            watch_reset_flag <= (watch_reset_flag && !watch_reset_flag_clr)
                                || cnt_bus.timeout;
        end
    end

    // ======================================================================
    // interrupt status, mask and output
    always_comb begin
        int_set = '0;
        int_set[`WDT_IRQ_RESET_BIT] = awake_timeout;
        int_set[`WDT_IRQ_WAKE_BIT]  = sleep_timeout;
        int_clr = wr_int_stat ? w_data_r[`WDT_IRQ_W-1:0] : '0;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            int_stat_r <= '0;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_set;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            int_mask_r <= '0;
        end else if (wr_int_mask) begin
            int_mask_r <= w_data_r[`WDT_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((int_stat_r & ~int_clr) | int_set) & int_mask_r);
        end
    end

    // ======================================================================
    // control register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sw_watch_enable_r  <= 1'(`WDT_CTRL_RESET >> `WDT_CTRL_EN_BIT);
            watch_period_sel_r <= `WDT_PS_RESET;
        end else if (wr_ctrl) begin
            sw_watch_enable_r  <= w_data_r[`WDT_CTRL_EN_BIT];
            watch_period_sel_r <=
                w_data_r[`WDT_CTRL_PS_MSB:`WDT_CTRL_PS_LSB];
        end
    end

    // ======================================================================
    // write address decode
    always_comb begin
        wr_fire     = (wr_state_r == wdt_pkg::WR_COLLECT)
                      && aw_held_r && w_held_r;
        wr_lane0    = wr_fire && w_strb_r[0];
        wr_ctrl     = wr_lane0 && (aw_addr_r == `WDT_OFS_CTRL);
        wr_status   = wr_lane0 && (aw_addr_r == `WDT_OFS_STATUS);
        wr_int_stat = wr_lane0 && (aw_addr_r == `WDT_OFS_INT_STAT);
        wr_int_mask = wr_lane0 && (aw_addr_r == `WDT_OFS_INT_MASK);
        case (aw_addr_r)
            `WDT_OFS_CTRL,
            `WDT_OFS_STATUS,
            `WDT_OFS_INT_STAT,
            `WDT_OFS_INT_MASK: begin
                wr_mapped = 1'b1;
            end
            default: begin
                wr_mapped = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // write address and data capture, either order
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[3:2], 2'h0};
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
                             && (wr_state_r == wdt_pkg::WR_COLLECT);
            s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
                             && (wr_state_r == wdt_pkg::WR_COLLECT);
        end
    end

    // ======================================================================
    // write response
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wr_state_r   <= wdt_pkg::WR_COLLECT;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `WDT_RESP_OKAY;
        end else begin
            case (wr_state_r)
                wdt_pkg::WR_COLLECT: begin
                    if (wr_fire) begin
                        wr_state_r   <= wdt_pkg::WR_RESPOND;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_mapped ? `WDT_RESP_OKAY
                                                  : `WDT_RESP_SLVERR;
                    end
                end
                wdt_pkg::WR_RESPOND: begin
                    if (s_axi_bready) begin
                        wr_state_r   <= wdt_pkg::WR_COLLECT;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state_r   <= wdt_pkg::WR_COLLECT;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // ======================================================================
    // read decode
    always_comb begin
        rd_word   = '0;
        rd_mapped = 1'b1;
        case ({s_axi_araddr[3:2], 2'h0})
            `WDT_OFS_CTRL: begin
                rd_word[`WDT_CTRL_EN_BIT] = sw_watch_enable_r;
                rd_word[`WDT_CTRL_PS_MSB:`WDT_CTRL_PS_LSB] =
                    watch_period_sel_r;
            end
            `WDT_OFS_STATUS: begin
                rd_word[`WDT_ST_PD_BIT]    = powerdown_flag_n;
                rd_word[`WDT_ST_TO_BIT]    = timeout_flag_n;
                rd_word[`WDT_ST_WATCH_RESET_FLAG_BIT]  = watch_reset_flag;
                rd_word[`WDT_ST_SLEEP_BIT] = asleep;
            end
            `WDT_OFS_INT_STAT: begin
                rd_word[`WDT_IRQ_W-1:0] = int_stat_r;
            end
            `WDT_OFS_INT_MASK: begin
                rd_word[`WDT_IRQ_W-1:0] = int_mask_r;
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // read channel
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `WDT_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule : watchdog_timer_sleep_aware

// file: sim/wdt_properties.sv
// concurrent checks on the watchdog block ports
`timescale 1ns/10ps
module wdt_properties (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic [1:0] wdt_mode_cfg,
    input wire logic       clear_watch_instr,
    input wire logic       sleep_req,
    input wire logic       ext_wake,
    input wire logic       osc_fail,
    input wire logic       wdt_reset_req,
    input wire logic       wake_req,
    input wire logic       asleep,
    input wire logic       timeout_flag_n,
    input wire logic       powerdown_flag_n,
    input wire logic       watch_reset_flag
);
    // ====================
    // sleep entry steps
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_enter; sleep_req && !asleep; endsequence
    sequence s_parked;
        asleep && !powerdown_flag_n && timeout_flag_n;
    endsequence
    // ====================
    // properties
    AST_SLEEP_ENTRY: assert property (s_enter |=> s_parked)
        else $error("sleep entry flags wrong");
    AST_SLEEP_CAUSE: assert property ($rose(asleep) |->
        $past(sleep_req)) else $error("sleep without request");
    AST_AWAKE_RESET: assert property (wdt_reset_req |->
        !asleep && !timeout_flag_n && watch_reset_flag)
        else $error("reset flags wrong");
    AST_SLEEP_WAKE: assert property (wake_req |-> $past(asleep) &&
        !asleep && !wdt_reset_req) else $error("wake wrong");
    AST_MODE_OFF: assert property ((wdt_mode_cfg == 2'b00)[*3]
        |-> !wdt_reset_req) else $error("reset while off");
    AST_SLEEP_OFF: assert property ((asleep &&
        wdt_mode_cfg == 2'b10 && !ext_wake)[*3] |-> !wake_req)
        else $error("wake in mode 10 sleep");
    AST_CLEARED: assert property ((clear_watch_instr || osc_fail) |->
        ##2 (!wdt_reset_req)[*8]) else $error("reset soon after clear");
    AST_ONE_PULSE: assert property ((wake_req || wdt_reset_req) |=>
        !(wake_req || wdt_reset_req)) else $error("pulse too long");
endmodule : wdt_properties

bind watchdog_timer_sleep_aware wdt_properties wdt_properties_i (
    .clock, .rst_b, .wdt_mode_cfg, .clear_watch_instr, .sleep_req,
    .ext_wake, .osc_fail, .wdt_reset_req, .wake_req, .asleep,
    .timeout_flag_n, .powerdown_flag_n, .watch_reset_flag
);

// file: sim/cpu_core_model.sv
// core model issuing periodic clear instructions
`timescale 1ns/10ps
module cpu_core_model #(
    parameter int GAP = 100
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic kick_en,
    output logic      clear_watch_instr
);
    logic [7:0] gap_r;
    // ====================
    // kick timer
    always_ff @(posedge clock) begin
        if (!rst_b || !kick_en) begin
            gap_r <= 8'h00;
            clear_watch_instr <= 1'b0;
        end else begin
            gap_r <= (gap_r == 8'(GAP - 1)) ? 8'h00 : gap_r + 8'h01;
            clear_watch_instr <= (gap_r == 8'(GAP - 1));
        end
    end
endmodule : cpu_core_model

// file: sim/watchdog_timer_sleep_aware_tb_top.sv
// self-checking bench for the watchdog block
`timescale 1ns/10ps
module watchdog_timer_sleep_aware_tb_top;
    // ====================
    // signals
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic [2:0]  oc = 3'h0;
    logic [1:0]  wdt_mode_cfg = 2'h0;
    logic        sleep_req = 1'b0, ext_wake = 1'b0, osc_fail = 1'b0;
    logic        kick_en = 1'b0, clear_watch_instr, wdt_reset_req, wake_req;
    logic        asleep, timeout_flag_n, powerdown_flag_n, watch_reset_flag;
    logic        irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          err_total = 0, n_tests = 0, n_rst, n_wake;

    watchdog_timer_sleep_aware watchdog_timer_sleep_aware_i (
        .clock, .rst_b, .low_freq_int_osc(oc[2]), .wdt_mode_cfg,
        .clear_watch_instr, .sleep_req, .ext_wake, .osc_fail, .wdt_reset_req,
        .wake_req, .asleep, .timeout_flag_n, .powerdown_flag_n,
        .watch_reset_flag, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    cpu_core_model cpu_core_model_i (.clock, .rst_b, .kick_en,
        .clear_watch_instr);

    // ====================
    // helpers
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : chk
    task run(input int n);
        n_rst = 0;
        n_wake = 0;
        repeat (n) begin
            @(posedge clock);
            n_rst += int'(wdt_reset_req === 1'b1);
            n_wake += int'(wake_req === 1'b1);
        end
    endtask : run
    task restart;
        osc_fail <= 1'b1;
        @(posedge clock);
        osc_fail <= 1'b0;
    endtask : restart
    task nap;
        sleep_req <= 1'b1;
        @(posedge clock);
        sleep_req <= 1'b0;
    endtask : nap
    task wr(input logic [3:0] a, input logic [31:0] d);
        bit aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'h0, 32'(s_axi_bresp));
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk("rresp", 32'h0, 32'(s_axi_rresp));
    endtask : rd

    // ====================
    // scenarios
    task automatic t_modes;
        logic [1:0] md[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
        logic [7:0] cf[7] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h26, 8'h02};
        int         ex[7] = '{0, 0, 1, 1, 1, 1, 0};
        rd(4'h0, rdat);
        chk("ctrl", 32'h16, rdat);
        for (int i = 0; i < 7; i++) begin
            wr(4'h0, {24'h0, cf[i]});
            wdt_mode_cfg <= md[i];
            restart();
            run(400);
            chk("resets", 32'(ex[i]),
                32'(n_rst));
        end
        rd(4'h4, rdat);
        chk("status", 32'h5, rdat);
    endtask : t_modes
    task t_irq;
        wdt_mode_cfg <= 2'h0;
        wr(4'hc, 32'h0);
        run(3);
        chk("irq masked", 32'h0, 32'(irq));
        wr(4'hc, 32'h1);
        run(3);
        chk("irq", 32'h1, 32'(irq));
        wr(4'h8, 32'h1);
        wr(4'h4, 32'h4);
        run(3);
        chk("irq cleared", 32'h0, 32'(irq));
        chk("reset record", 32'h0, 32'(watch_reset_flag));
    endtask : t_irq
    task t_sleep;
        wdt_mode_cfg <= 2'h3;
        wr(4'h0, 32'h0);
        nap();
        run(400);
        chk("wakes", 32'h1, 32'(n_wake));
        chk("resets", 32'h0, 32'(n_rst));
        chk("flags", 32'h0,
            {30'h0, timeout_flag_n, powerdown_flag_n});
        chk("reset record", 32'h1, 32'(watch_reset_flag));
        rd(4'h8, rdat);
        chk("int stat", 32'h2, rdat);
        wdt_mode_cfg <= 2'h2;
        nap();
        run(400);
        chk("wakes", 32'h0, 32'(n_wake + n_rst));
        ext_wake <= 1'b1;
        @(posedge clock);
        ext_wake <= 1'b0;
        run(3);
        chk("asleep", 32'h0, 32'(asleep));
    endtask : t_sleep
    task t_kick;
        wdt_mode_cfg <= 2'h3;
        kick_en <= 1'b1;
        restart();
        run(800);
        chk("resets", 32'h0, 32'(n_rst));
        kick_en <= 1'b0;
        run(400);
        chk("resets", 32'h1, 32'(n_rst));
    endtask : t_kick

    // ====================
    // run control
    task end_sim;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial forever #5 clock = ~clock;
    always @(posedge clock) oc <= oc + 3'h1;
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        t_modes();
        t_irq();
        t_sleep();
        t_kick();
        end_sim();
    end
endmodule : watchdog_timer_sleep_aware_tb_top
